// file: hdl/sllrc_defines.svh
// register offsets, field positions and timing counts for the supply low detector
`ifndef SLLRC_DEFINES_SVH
`define SLLRC_DEFINES_SVH
`define SLLRC_OFS_CONTROL 16'hF890
`define SLLRC_OFS_MODE 16'hF892
`define SLLRC_OFS_SAMPLING 16'hF896
`define SLLRC_OFS_IRQ_STATUS 16'hF898
`define SLLRC_OFS_IRQ_MASK 16'hF89C
`define SLLRC_CTL_EN 0
`define SLLRC_CTL_FLAG 1
`define SLLRC_CTL_READY 2
`define SLLRC_MOD_RSTSEL 0
`define SLLRC_SMP_SRC 3
`define SLLRC_SMP_DIV_LO 4
`define SLLRC_SMP_DIV_HI 5
`define SLLRC_REG_RESET 8'h00
`define SLLRC_SETTLE_US 300
`define SLLRC_CLK_MHZ 25
`define SLLRC_SETTLE_CYC (`SLLRC_SETTLE_US * `SLLRC_CLK_MHZ)
`define SLLRC_HOLD_SAMPLES 3
`define SLLRC_LS_DIV 763
`endif

// file: hdl/sllrc_pkg.sv
// types shared by the supply low detector files
package sllrc_pkg;
	typedef enum logic [1:0] {
		SLLRC_OFF = 2'b00,
		SLLRC_SETTLE = 2'b01,
		SLLRC_RUN = 2'b10
	} sllrc_state_t;
endpackage

// file: hdl/sllrc_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module sllrc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// level in and out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: hdl/sllrc_sampler.sv
// low-speed sampling clock divider and three-sample comparator filter
`timescale 1ns/100ps
`default_nettype none
`include "sllrc_defines.svh"
module sllrc_sampler #(
	parameter int LS_DIV = `SLLRC_LS_DIV
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic sample_on,
	input wire logic [1:0] div_sel,
	input wire logic cmp_low,
	// filtered result
	output logic filt_low,
	output logic filt_valid
);
	localparam int LSW = $clog2(LS_DIV + 1);
	logic [LSW-1:0] ls_cnt_q;
	logic ls_tick;
	logic [2:0] div_cnt_q;
	logic smp_tick;
	logic [1:0] same_cnt_q;
	logic last_q;
	logic [1:0] seen_q;

	////////////////////////////////////////////////////////////////////////
	// low-speed clock enable, then 1/1, 1/2, 1/4 or 1/8 of it
	assign ls_tick = (ls_cnt_q == LSW'(LS_DIV - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_cnt_q <= '0;
		end else if (ls_tick || !run) begin
			ls_cnt_q <= '0;
		end else begin
			ls_cnt_q <= ls_cnt_q + LSW'(1);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 3'h0;
		end else if (!run) begin
			div_cnt_q <= 3'h0;
		end else if (ls_tick) begin
			div_cnt_q <= div_cnt_q + 3'h1;
		end
	end
	assign smp_tick = ls_tick &&
		((3'(({1'b0, div_cnt_q} + 4'h1)) & ((3'h1 << div_sel) - 3'h1)) == 3'h0);

	////////////////////////////////////////////////////////////////////////
	// with sample_on set, result changes only after three equal samples; with it clear, result follows cmp_low each cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			same_cnt_q <= 2'h0;
			last_q <= 1'b0;
			filt_low <= 1'b0;
			seen_q <= 2'h0;
			filt_valid <= 1'b0;
		end else if (!run) begin
			same_cnt_q <= 2'h0;
			last_q <= 1'b0;
			filt_low <= 1'b0;
			seen_q <= 2'h0;
			filt_valid <= 1'b0;
		end else if (!sample_on) begin
			filt_low <= cmp_low;
			filt_valid <= 1'b1;
		end else if (smp_tick) begin
			last_q <= cmp_low;
			if (cmp_low != last_q) begin
				same_cnt_q <= 2'h1;
			end else if (same_cnt_q != 2'(`SLLRC_HOLD_SAMPLES)) begin
				same_cnt_q <= same_cnt_q + 2'h1;
			end
			if (cmp_low == last_q && same_cnt_q == 2'(`SLLRC_HOLD_SAMPLES - 1)) begin
				filt_low <= cmp_low;
			end
			if (seen_q != 2'(`SLLRC_HOLD_SAMPLES)) begin
				seen_q <= seen_q + 2'h1;
			end else begin
				filt_valid <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/sllrc_top.sv
// supply low detector control: apb registers, settle timer, flag and reset
`timescale 1ns/100ps
`default_nettype none
`include "sllrc_defines.svh"
module sllrc_top #(
	parameter int SETTLE_CYC = `SLLRC_SETTLE_CYC,
	parameter int LS_DIV = `SLLRC_LS_DIV
) (
	// apb clock and power-on or pin reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparator, high while supply is below threshold
	input wire logic cmp_low,
	output logic detector_on,
	// reset request and interrupt
	output logic low_reset_req,
	output logic irq
);
	sllrc_pkg::sllrc_state_t state_q;
	logic en_q;
	logic rstsel_q;
	logic smp_src_q;
	logic [1:0] smp_div_q;
	logic flag_q;
	logic ready_q;
	logic [31:0] settle_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic cmp_sync;
	logic filt_low;
	logic filt_valid;
	logic wr;
	logic rd;
	logic flag_clr;
	logic start;
	logic [1:0] ev;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		// byte registers share words, so the full byte address selects
		hit = (a == ofs);
	endfunction
	function automatic logic [7:0] lane(input logic [15:0] a,
		input logic [31:0] d);
		lane = d[8*a[1:0] +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// comparator input crossing and sampling filter
	sllrc_sync #(.WIDTH(1)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(cmp_low),
		.sync_out(cmp_sync)
	);

	sllrc_sampler #(.LS_DIV(LS_DIV)) u_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.run(state_q == sllrc_pkg::SLLRC_RUN),
		.sample_on(smp_src_q),
		.div_sel(smp_div_q),
		.cmp_low(cmp_sync),
		.filt_low(filt_low),
		.filt_valid(filt_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// apb access, zero wait states, unmapped addresses answer pslverr
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			if (hit(paddr, `SLLRC_OFS_CONTROL)) begin
				pslverr = 1'b0;
			end else if (hit(paddr, `SLLRC_OFS_MODE)) begin
				pslverr = 1'b0;
			end else if (hit(paddr, `SLLRC_OFS_SAMPLING)) begin
				pslverr = 1'b0;
			end else if (hit(paddr, `SLLRC_OFS_IRQ_STATUS)) begin
				pslverr = 1'b0;
			end else if (hit(paddr, `SLLRC_OFS_IRQ_MASK)) begin
				pslverr = 1'b0;
			end else begin
				pslverr = 1'b1;
			end
		end
	end

	// the byte lane of each register is selected by its own address bits
	function automatic logic lane_on(input logic [15:0] ofs,
		input logic [3:0] s);
		lane_on = s[ofs[1:0]];
	endfunction

	assign flag_clr = wr && hit(paddr, `SLLRC_OFS_CONTROL) &&
		lane_on(`SLLRC_OFS_CONTROL, pstrb) &&
		lane(`SLLRC_OFS_CONTROL, pwdata)[`SLLRC_CTL_FLAG];

	////////////////////////////////////////////////////////////////////////
	// configuration registers, cleared only by presetn (power-on or pin)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
		end else if (wr && hit(paddr, `SLLRC_OFS_CONTROL) &&
			lane_on(`SLLRC_OFS_CONTROL, pstrb)) begin
			en_q <= lane(`SLLRC_OFS_CONTROL, pwdata)[`SLLRC_CTL_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rstsel_q <= 1'b0;
		end else if (wr && hit(paddr, `SLLRC_OFS_MODE) &&
			lane_on(`SLLRC_OFS_MODE, pstrb)) begin
			rstsel_q <= lane(`SLLRC_OFS_MODE, pwdata)[`SLLRC_MOD_RSTSEL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_src_q <= 1'b0;
			smp_div_q <= 2'h0;
		end else if (wr && hit(paddr, `SLLRC_OFS_SAMPLING) &&
			lane_on(`SLLRC_OFS_SAMPLING, pstrb)) begin
			smp_src_q <= lane(`SLLRC_OFS_SAMPLING, pwdata)[`SLLRC_SMP_SRC];
			smp_div_q <= lane(`SLLRC_OFS_SAMPLING, pwdata)
				[`SLLRC_SMP_DIV_HI:`SLLRC_SMP_DIV_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// detector sequencing: off, settling, running
	assign start = (state_q == sllrc_pkg::SLLRC_OFF) && en_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sllrc_pkg::SLLRC_OFF;
			settle_q <= 32'h0;
		end else begin
			case (state_q)
				sllrc_pkg::SLLRC_OFF: begin
					settle_q <= 32'h0;
					if (en_q) begin
						state_q <= sllrc_pkg::SLLRC_SETTLE;
					end
				end
				sllrc_pkg::SLLRC_SETTLE: begin
					settle_q <= settle_q + 32'h1;
					if (!en_q) begin
						state_q <= sllrc_pkg::SLLRC_OFF;
					end else if (settle_q == 32'(SETTLE_CYC - 1)) begin
						state_q <= sllrc_pkg::SLLRC_RUN;
					end
				end
				sllrc_pkg::SLLRC_RUN: begin
					if (!en_q) begin
						state_q <= sllrc_pkg::SLLRC_OFF;
					end
				end
				default: begin
					state_q <= sllrc_pkg::SLLRC_OFF;
				end
			endcase
		end
	end

	// only presetn or clearing en_q stops the sequencer, so other resets leave it running
	assign detector_on = en_q && (state_q != sllrc_pkg::SLLRC_OFF);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (state_q == sllrc_pkg::SLLRC_RUN) && en_q && filt_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// low-voltage flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (start || !en_q) begin
			flag_q <= 1'b0;
		end else if (!ready_q) begin
			flag_q <= 1'b0;
		end else if (filt_low) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= 1'b0;
		end
	end

	assign low_reset_req = flag_q && rstsel_q && ready_q;

	////////////////////////////////////////////////////////////////////////
	// interrupt: bit 0 flag rise, bit 1 ready rise; write one clears
	logic flag_d1_q;
	logic ready_d1_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_d1_q <= 1'b0;
			ready_d1_q <= 1'b0;
		end else begin
			flag_d1_q <= flag_q;
			ready_d1_q <= ready_q;
		end
	end
	assign ev = {ready_q && !ready_d1_q, flag_q && !flag_d1_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 2'h0;
		end else if (wr && hit(paddr, `SLLRC_OFS_IRQ_STATUS) && pstrb[0]) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | ev;
		end else begin
			irq_stat_q <= irq_stat_q | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= 2'h0;
		end else if (wr && hit(paddr, `SLLRC_OFS_IRQ_MASK) && pstrb[0]) begin
			irq_mask_q <= pwdata[1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////
	// read data, reserved bits zero
	always_comb begin
		prdata = 32'h0;
		if (rd) begin
			if (hit(paddr, `SLLRC_OFS_CONTROL)) begin
				prdata[8*`SLLRC_OFS_CONTROL%4 +: 8] = {5'h0, ready_q, flag_q, en_q};
			end else if (hit(paddr, `SLLRC_OFS_MODE)) begin
				prdata[8*(`SLLRC_OFS_MODE%4) +: 8] = {7'h0, rstsel_q};
			end else if (hit(paddr, `SLLRC_OFS_SAMPLING)) begin
				prdata[8*(`SLLRC_OFS_SAMPLING%4) +: 8] =
					{2'h0, smp_div_q, smp_src_q, 3'h0};
			end else if (hit(paddr, `SLLRC_OFS_IRQ_STATUS)) begin
				prdata = {30'h0, irq_stat_q};
			end else if (hit(paddr, `SLLRC_OFS_IRQ_MASK)) begin
				prdata = {30'h0, irq_mask_q};
			end else begin
				prdata = 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/sllrc_top_asserts.sv
// port checks for the supply low detector
`timescale 1ns/100ps
`default_nettype none
`include "sllrc_defines.svh"
module sllrc_top_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// detector outputs
	input wire logic detector_on,
	input wire logic low_reset_req,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc(logic [15:0] a);
		psel && penable && paddr == a;
	endsequence
	sequence s_ctl_wr(logic v);
		s_acc(`SLLRC_OFS_CONTROL) ##0 pwrite && pstrb[0] && pwdata[0] == v;
	endsequence
	property p_en_on;
		s_ctl_wr(1'b1) |-> ##[1:2] detector_on;
	endproperty
	property p_dis_off;
		s_ctl_wr(1'b0) |-> ##[1:2] !detector_on;
	endproperty
	property p_off_no_req;
		!detector_on [*2] |-> !low_reset_req;
	endproperty
	property p_ready_mask;
		$rose(detector_on) |-> !low_reset_req [*8];
	endproperty
	property p_boot;
		$rose(presetn) |-> !detector_on && !low_reset_req && !irq;
	endproperty
	property p_ctl_rsv;
		s_acc(`SLLRC_OFS_CONTROL) ##0 !pwrite |-> prdata[7:3] == 5'h00;
	endproperty
	property p_mod_rsv;
		s_acc(`SLLRC_OFS_MODE) ##0 !pwrite |-> prdata[23:18] == 6'h00;
	endproperty
	property p_smp_rsv;
		s_acc(`SLLRC_OFS_SAMPLING) ##0 !pwrite |->
			prdata[23:22] == 2'h0 && prdata[18:16] == 3'h0;
	endproperty
	property p_unmapped;
		s_acc(16'hF894) |-> pslverr;
	endproperty
	a_en_on: assert property (p_en_on) else $error("enable not seen");
	a_dis_off: assert property (p_dis_off) else $error("still on");
	a_off_no_req: assert property (p_off_no_req) else $error("req off");
	a_ready_mask: assert property (p_ready_mask) else $error("early req");
	a_boot: assert property (p_boot) else $error("reset state");
	a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctl rsv");
	a_mod_rsv: assert property (p_mod_rsv) else $error("mode rsv");
	a_smp_rsv: assert property (p_smp_rsv) else $error("smp rsv");
	a_unmapped: assert property (p_unmapped) else $error("no slverr");
endmodule
`default_nettype wire

// file: test/sllrc_supply_model.sv
// behavioural supply comparator on the far side of the detector
`timescale 1ns/100ps
`default_nettype none
module sllrc_supply_model (
	// clock
	input wire logic pclk,
	// analog side
	input wire logic detector_on,
	input wire logic supply_low,
	output logic cmp_low
);
	logic idle_q = 1'b0;
	always_ff @(posedge pclk) begin
		idle_q <= ~idle_q;
	end
	// a stopped comparator has no valid level, so it wanders
	assign cmp_low = detector_on ? supply_low : idle_q;
endmodule
`default_nettype wire

// file: test/supply_low_level_reset_control_test.sv
// self-checking bench for the supply low detector
`timescale 1ns/100ps
`default_nettype none
`include "sllrc_defines.svh"
module supply_low_level_reset_control_test;
	localparam logic [15:0] CTL = `SLLRC_OFS_CONTROL;
	localparam logic [15:0] MDR = `SLLRC_OFS_MODE;
	localparam logic [15:0] SMP = `SLLRC_OFS_SAMPLING;
	localparam logic [15:0] IST = `SLLRC_OFS_IRQ_STATUS;
	localparam logic [15:0] IMK = `SLLRC_OFS_IRQ_MASK;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic supply_low = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, cmp_low, detector_on, low_reset_req, irq, err;
	logic [7:0] rv;
	int num_errors = 0;
	int comparisons = 0;
	always #20 pclk = ~pclk;
	sllrc_top #(.SETTLE_CYC(20), .LS_DIV(4)) sllrc_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_low(cmp_low), .detector_on(detector_on),
		.low_reset_req(low_reset_req), .irq(irq));
	sllrc_supply_model sllrc_supply_model_inst (.pclk(pclk),
		.detector_on(detector_on), .supply_low(supply_low),
		.cmp_low(cmp_low));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {4{d}};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rv = prdata[8*a[1:0] +: 8];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		check(rv, e);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		rv = 8'h00;
		while (rv[2] !== 1'b1 && n < 200) begin
			xfer(1'b0, CTL, 8'h00);
			n++;
		end
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(40 * 6000);
		num_errors++;
		end_of_test();
	end
	initial begin
		do_reset();
		rc(CTL, 8'h00);
		rc(MDR, 8'h00);
		rc(SMP, 8'h00);
		xfer(1'b0, 16'hF894, 8'h00);
		check(err, 1'h1);
		// reset-select set while stopped, reserved bits 7:2 written as 1 and read back as 0
		xfer(1'b1, MDR, 8'hFD);
		rc(MDR, 8'h01);
		xfer(1'b1, SMP, 8'hFF);
		rc(SMP, 8'h38);
		xfer(1'b1, SMP, 8'h00);
		// low supply at enable: flag and request held off until ready
		xfer(1'b1, IMK, 8'h03);
		supply_low <= 1'b1;
		xfer(1'b1, CTL, 8'h01);
		rc(CTL, 8'h01);
		@(negedge pclk);
		check(low_reset_req, 1'h0);
		wait_ready();
		repeat (4) @(posedge pclk);
		rc(CTL, 8'h07);
		@(negedge pclk);
		check(low_reset_req, 1'h1);
		check(irq, 1'h1);
		rc(IST, 8'h03);
		xfer(1'b1, IST, 8'h03);
		@(negedge pclk);
		check(irq, 1'h0);
		// flag writes while the supply is still low
		xfer(1'b1, CTL, 8'h01);
		rc(CTL, 8'h07);
		xfer(1'b1, CTL, 8'h03);
		rc(CTL, 8'h07);
		supply_low <= 1'b0;
		repeat (4) @(posedge pclk);
		rc(CTL, 8'h05);
		@(negedge pclk);
		check(low_reset_req, 1'h0);
		xfer(1'b1, CTL, 8'h00);
		supply_low <= 1'b1;
		repeat (6) @(posedge pclk);
		rc(CTL, 8'h00);
		check(detector_on, 1'h0);
		// sampling at 1/2: flag waits for three equal samples, irq masked
		supply_low <= 1'b0;
		xfer(1'b1, IMK, 8'h00);
		xfer(1'b1, SMP, 8'h18);
		xfer(1'b1, CTL, 8'h01);
		wait_ready();
		supply_low <= 1'b1;
		repeat (4) @(posedge pclk);
		rc(CTL, 8'h05);
		repeat (80) @(posedge pclk);
		rc(CTL, 8'h07);
		rc(IST, 8'h03);
		@(negedge pclk);
		check(irq, 1'h0);
		// pin reset mid-run clears all three registers
		do_reset();
		rc(CTL, 8'h00);
		rc(MDR, 8'h00);
		rc(SMP, 8'h00);
		end_of_test();
	end
endmodule
bind sllrc_top sllrc_top_asserts sllrc_top_asserts_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pslverr(pslverr), .detector_on(detector_on),
	.low_reset_req(low_reset_req), .irq(irq));
`default_nettype wire
